// [hdl/dsh_regs.vh]
`ifndef DSH_REGS_VH
`define DSH_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define DSH_CLK_MHZ 25
// counts in clk_sys cycles: 350 ms, 4.1 ms, 350 ms
`define DSH_T_SWITCH_CYC 24'h85_83b0
`define DSH_T_PAUSE_CYC 24'h01_9064
`define DSH_T_DISC_CYC 24'h85_83b0
`define DSH_CNT_W 24

// ----------------------------------------
// synchroniser vector layout
// ----------------------------------------
`define DSH_SYNC_W 10
`define DSH_B_DP_HPD 0
`define DSH_B_TMDS_HPD 1
`define DSH_B_CAD 2
`define DSH_B_PRIO 3
`define DSH_B_EN 4
`define DSH_B_OVS 5
`define DSH_B_SRC_DDC 6
`define DSH_B_SNK_DDC 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define DSH_SYNC_RST 10'h3c0
`define DSH_CNT_RST 24'h00_0000

`endif

// [hdl/dsh_sync.v]
`timescale 1ns/1ps
`include "dsh_regs.vh"
module dsh_sync
(
  input wire clk_sys,
  input wire rst_n,
  input wire [`DSH_SYNC_W-1:0] d,
  output wire [`DSH_SYNC_W-1:0] q
);

  // ----------------------------------------
  // three stages, change taken when 2 and 3 agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `DSH_SYNC_W; i = i + 1)
    begin : g_bit
      localparam [`DSH_SYNC_W-1:0] RV = `DSH_SYNC_RST;
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg q_r;
      always @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_r <= RV[i];
          s2_r <= RV[i];
          s3_r <= RV[i];
          q_r <= RV[i];
        end
        else
        begin
          s1_r <= d[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // rejects a single-cycle glitch on the pin
          if (s2_r == s3_r)
            q_r <= s3_r;
        end
      end
      assign q[i] = q_r;
    end
  endgenerate

endmodule

// [hdl/dsh_ctl.v]
`timescale 1ns/1ps
`include "dsh_regs.vh"
module dsh_ctl
#(
  parameter [`DSH_CNT_W-1:0] T_SWITCH_CYC = `DSH_T_SWITCH_CYC,
  parameter [`DSH_CNT_W-1:0] T_PAUSE_CYC = `DSH_T_PAUSE_CYC,
  parameter [`DSH_CNT_W-1:0] T_DISC_CYC = `DSH_T_DISC_CYC
)
(
  input wire clk_sys,
  input wire resetn,
  input wire enable_in,
  input wire priority_in,
  input wire dp_sink_hotplug_in,
  input wire tmds_sink_hotplug_in,
  input wire sink_cable_adapter_in,
  input wire ddc_low_level_select,
  input wire force_mode_in,
  input wire force_hotplug_in,
  input wire force_cable_adapter_in,
  input wire source_ddc_data_in,
  input wire source_ddc_clock_in,
  input wire sink_ddc_data_in,
  input wire sink_ddc_clock_in,
  output reg source_hotplug_out,
  output reg source_cable_adapter_out,
  output reg ddc_pullup_enable_out,
  output reg source_aux_channel_switch_out,
  output reg source_ddc_switch_out,
  output reg sink_aux_channel_switch_out,
  output reg ddc_level_buffer_enable_out,
  output reg link_train_monitor_out,
  output reg adaptor_id_enable_out,
  output reg main_link_enable_out,
  output reg low_power_out,
  output reg ddc_low_level_select_out,
  output wire source_ddc_data_out,
  output wire source_ddc_data_oe,
  output wire source_ddc_clock_out,
  output wire source_ddc_clock_oe,
  output wire sink_ddc_data_out,
  output wire sink_ddc_data_oe,
  output wire sink_ddc_clock_out,
  output wire sink_ddc_clock_oe
);

  localparam [2:0] S_NONE = 3'h0;
  localparam [2:0] S_DP = 3'h1;
  localparam [2:0] S_TMDS = 3'h2;
  localparam [2:0] S_HOLD = 3'h3;
  localparam [2:0] S_PAUSE = 3'h4;

  localparam [1:0] D_IDLE = 2'h0;
  localparam [1:0] D_SNK = 2'h1;
  localparam [1:0] D_SRC = 2'h2;
  localparam [1:0] D_REL = 2'h3;

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  reg rst1_r;
  reg rst_n_r;
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst1_r <= 1'b1;
      rst_n_r <= rst1_r;
    end
  end

  wire [`DSH_SYNC_W-1:0] pin_raw;
  wire [`DSH_SYNC_W-1:0] pin_s;
  assign pin_raw = {sink_ddc_clock_in, sink_ddc_data_in,
    source_ddc_clock_in, source_ddc_data_in, ddc_low_level_select,
    enable_in, priority_in, sink_cable_adapter_in,
    tmds_sink_hotplug_in, dp_sink_hotplug_in};

  dsh_sync u_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .d(pin_raw),
    .q(pin_s)
  );

  wire hpd_s [0:1];
  assign hpd_s[0] = pin_s[`DSH_B_DP_HPD];
  assign hpd_s[1] = pin_s[`DSH_B_TMDS_HPD];
  wire cad_s = pin_s[`DSH_B_CAD];
  wire prio_s = pin_s[`DSH_B_PRIO];
  wire en_s = pin_s[`DSH_B_EN];

  // ----------------------------------------
  // enable: edge detect and override latches
  // ----------------------------------------
  reg en_d_r;
  reg frc_mode_r;
  reg frc_hpd_r;
  reg frc_cad_r;
  wire en_rise = en_s & ~en_d_r;
  always @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      en_d_r <= 1'b0;
      frc_mode_r <= 1'b0;
      frc_hpd_r <= 1'b0;
      frc_cad_r <= 1'b0;
    end
    else
    begin
      en_d_r <= en_s;
      // defaults while off, and once more on the rising edge
      if (!en_s || en_rise)
      begin
        frc_mode_r <= 1'b0;
        frc_hpd_r <= 1'b0;
        frc_cad_r <= 1'b0;
      end
      else
      begin
        frc_mode_r <= force_mode_in;
        frc_hpd_r <= force_hotplug_in;
        frc_cad_r <= force_cable_adapter_in;
      end
    end
  end

  // ----------------------------------------
  // per-sink disconnect filter
  // ----------------------------------------
  wire conn [0:1];
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1)
    begin : g_sink
      reg conn_r;
      reg [`DSH_CNT_W-1:0] low_cnt_r;
      always @(posedge clk_sys or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          conn_r <= 1'b0;
          low_cnt_r <= `DSH_CNT_RST;
        end
        else if (hpd_s[k])
        begin
          conn_r <= 1'b1;
          low_cnt_r <= `DSH_CNT_RST;
        end
        else if (conn_r)
        begin
          // a short drop (irq pulse) never reaches the selector
          if (low_cnt_r == T_DISC_CYC - 1'b1)
          begin
            conn_r <= 1'b0;
            low_cnt_r <= `DSH_CNT_RST;
          end
          else
            low_cnt_r <= low_cnt_r + 1'b1;
        end
      end
      assign conn[k] = conn_r;
    end
  endgenerate

  // ----------------------------------------
  // sink selection
  // ----------------------------------------
  wire want_dp = conn[0] & (~conn[1] | ~prio_s);
  wire want_tmds = conn[1] & (~conn[0] | prio_s);
  wire both = conn[0] & conn[1];

  // not cleared by enable, so a shutdown keeps the hotplug path
  reg [2:0] st_r;
  reg hold_dp_r;
  reg left_tmds_r;
  reg [`DSH_CNT_W-1:0] sw_cnt_r;
  always @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      st_r <= S_NONE;
      hold_dp_r <= 1'b0;
      left_tmds_r <= 1'b0;
      sw_cnt_r <= `DSH_CNT_RST;
    end
    else
    begin
      case (st_r)
        S_NONE:
        begin
          sw_cnt_r <= `DSH_CNT_RST;
          if (want_dp)
          begin
            st_r <= S_DP;
            left_tmds_r <= 1'b0;
          end
          else if (want_tmds)
            st_r <= S_TMDS;
        end
        S_DP:
        begin
          if (want_tmds && both)
          begin
            st_r <= S_HOLD;
            hold_dp_r <= 1'b1;
          end
          else if (want_tmds)
            st_r <= S_TMDS;
          else if (!want_dp)
            st_r <= S_NONE;
        end
        S_TMDS:
        begin
          if (want_dp && both)
          begin
            st_r <= S_HOLD;
            hold_dp_r <= 1'b0;
          end
          else if (want_dp)
          begin
            st_r <= S_DP;
            left_tmds_r <= 1'b0;
          end
          else if (!want_tmds)
          begin
            st_r <= S_NONE;
            left_tmds_r <= 1'b1;
          end
        end
        S_HOLD:
        begin
          if (sw_cnt_r == T_SWITCH_CYC - 1'b1)
          begin
            st_r <= S_PAUSE;
            sw_cnt_r <= `DSH_CNT_RST;
          end
          else
            sw_cnt_r <= sw_cnt_r + 1'b1;
        end
        S_PAUSE:
        begin
          if (sw_cnt_r == T_PAUSE_CYC - 1'b1)
          begin
            sw_cnt_r <= `DSH_CNT_RST;
            if (want_dp)
            begin
              st_r <= S_DP;
              left_tmds_r <= 1'b0;
            end
            else if (want_tmds)
              st_r <= S_TMDS;
            else
              st_r <= S_NONE;
          end
          else
            sw_cnt_r <= sw_cnt_r + 1'b1;
        end
        default:
          st_r <= S_NONE;
      endcase
    end
  end

  // ----------------------------------------
  // outputs toward source and switch controls
  // ----------------------------------------
  wire mode_dp = (st_r == S_DP) | ((st_r == S_HOLD) & hold_dp_r);
  wire mode_tmds = (st_r == S_TMDS) | ((st_r == S_HOLD) & ~hold_dp_r);
  reg hpd_nxt;
  reg cad_nxt;
  always @*
  begin
    hpd_nxt = mode_dp | mode_tmds;
    if (mode_dp)
      cad_nxt = cad_s;
    else if (mode_tmds)
      cad_nxt = 1'b1;
    else if (st_r == S_PAUSE)
      cad_nxt = source_cable_adapter_out;
    else
      cad_nxt = cad_s | left_tmds_r;
    if (frc_mode_r)
    begin
      hpd_nxt = frc_hpd_r;
      cad_nxt = frc_cad_r;
    end
  end

  always @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      source_hotplug_out <= 1'b0;
      source_cable_adapter_out <= 1'b0;
      ddc_pullup_enable_out <= 1'b0;
      source_aux_channel_switch_out <= 1'b0;
      source_ddc_switch_out <= 1'b0;
      sink_aux_channel_switch_out <= 1'b0;
      ddc_level_buffer_enable_out <= 1'b0;
      link_train_monitor_out <= 1'b0;
      adaptor_id_enable_out <= 1'b0;
      main_link_enable_out <= 1'b0;
      low_power_out <= 1'b1;
      ddc_low_level_select_out <= 1'b0;
    end
    else
    begin
      source_hotplug_out <= hpd_nxt;
      source_cable_adapter_out <= cad_nxt;
      ddc_pullup_enable_out <= cad_nxt;
      // all switches open in low power and during the pause
      source_aux_channel_switch_out <= mode_dp & ~cad_s;
      link_train_monitor_out <= mode_dp & ~cad_s;
      sink_aux_channel_switch_out <= mode_dp;
      source_ddc_switch_out <= (mode_dp & cad_s) | mode_tmds;
      ddc_level_buffer_enable_out <= mode_tmds;
      adaptor_id_enable_out <= mode_tmds;
      main_link_enable_out <= en_s & ~en_rise & (mode_dp | mode_tmds);
      low_power_out <= (st_r == S_NONE);
      ddc_low_level_select_out <= pin_s[`DSH_B_OVS];
    end
  end

  // ----------------------------------------
  // ddc level-shift buffer, one per line
  // ----------------------------------------
  wire [1:0] src_oe;
  wire [1:0] snk_oe;
  genvar j;
  generate
    for (j = 0; j < 2; j = j + 1)
    begin : g_ddc
      reg [1:0] dst_r;
      reg src_oe_r;
      reg snk_oe_r;
      // external driver must go below threshold to be seen here
      wire src_low = ~pin_s[`DSH_B_SRC_DDC + j];
      wire snk_high = pin_s[`DSH_B_SNK_DDC + j];
      always @(posedge clk_sys or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          dst_r <= D_IDLE;
          src_oe_r <= 1'b0;
          snk_oe_r <= 1'b0;
        end
        else if (!ddc_level_buffer_enable_out)
        begin
          dst_r <= D_IDLE;
          src_oe_r <= 1'b0;
          snk_oe_r <= 1'b0;
        end
        else
        begin
          case (dst_r)
            D_IDLE:
            begin
              if (src_low)
              begin
                dst_r <= D_SRC;
                src_oe_r <= 1'b1;
                snk_oe_r <= 1'b1;
              end
              else if (!snk_high)
              begin
                dst_r <= D_SNK;
                src_oe_r <= 1'b1;
              end
            end
            D_SNK:
            begin
              if (src_low)
              begin
                dst_r <= D_SRC;
                snk_oe_r <= 1'b1;
              end
              else if (snk_high)
              begin
                dst_r <= D_IDLE;
                src_oe_r <= 1'b0;
              end
            end
            D_SRC:
            begin
              // raised low level sits above threshold: no lock-up
              if (!src_low)
              begin
                dst_r <= D_REL;
                snk_oe_r <= 1'b0;
              end
            end
            D_REL:
            begin
              if (src_low)
              begin
                dst_r <= D_SRC;
                snk_oe_r <= 1'b1;
              end
              else if (snk_high)
              begin
                dst_r <= D_IDLE;
                src_oe_r <= 1'b0;
              end
            end
            default:
              dst_r <= D_IDLE;
          endcase
        end
      end
      assign src_oe[j] = src_oe_r;
      assign snk_oe[j] = snk_oe_r;
    end
  endgenerate

  // open-drain: only ever pulls low
  reg [3:0] od_lvl_r;
  always @(posedge clk_sys or negedge rst_n_r)
  begin
    if (!rst_n_r)
      od_lvl_r <= 4'h0;
    else
      od_lvl_r <= 4'h0;
  end

  assign source_ddc_data_oe = src_oe[0];
  assign source_ddc_clock_oe = src_oe[1];
  assign sink_ddc_data_oe = snk_oe[0];
  assign sink_ddc_clock_oe = snk_oe[1];
  assign source_ddc_data_out = od_lvl_r[0];
  assign source_ddc_clock_out = od_lvl_r[1];
  assign sink_ddc_data_out = od_lvl_r[2];
  assign sink_ddc_clock_out = od_lvl_r[3];

endmodule

// [testbench/dsh_sink_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// two display sinks: hotplug, adapter pin, sink-side ddc
// ----------------------------------------
module dsh_sink_model
(
  input wire dp_present,
  input wire tmds_present,
  input wire tmds_adapter,
  input wire hold_data_low,
  input wire hold_clock_low,
  input wire sink_ddc_data_oe,
  input wire sink_ddc_clock_oe,
  output wire dp_sink_hotplug_in,
  output wire tmds_sink_hotplug_in,
  output wire sink_cable_adapter_in,
  output wire sink_ddc_data_in,
  output wire sink_ddc_clock_in
);
  assign dp_sink_hotplug_in = dp_present;
  assign tmds_sink_hotplug_in = tmds_present;
  // adapter pin pulled low when no dp cable is plugged
  assign sink_cable_adapter_in = dp_present & tmds_adapter;
  // open drain with pull-up: any driver low wins, released goes high
  assign sink_ddc_data_in = ~(hold_data_low | sink_ddc_data_oe);
  assign sink_ddc_clock_in = ~(hold_clock_low | sink_ddc_clock_oe);
endmodule

// [testbench/dsh_ctl_props.sv]
`timescale 1ns/1ps
`include "dsh_regs.vh"
module dsh_ctl_props
#(
  parameter [`DSH_CNT_W-1:0] T_SWITCH_CYC = 20,
  parameter [`DSH_CNT_W-1:0] T_PAUSE_CYC = 5,
  parameter [`DSH_CNT_W-1:0] T_DISC_CYC = 16
)
(
  input wire clk_sys,
  input wire resetn,
  input wire enable_in,
  input wire force_mode_in,
  input wire source_ddc_data_in,
  input wire source_ddc_clock_in,
  input wire sink_ddc_clock_in,
  input wire source_hotplug_out,
  input wire source_cable_adapter_out,
  input wire ddc_pullup_enable_out,
  input wire source_aux_channel_switch_out,
  input wire source_ddc_switch_out,
  input wire sink_aux_channel_switch_out,
  input wire ddc_level_buffer_enable_out,
  input wire link_train_monitor_out,
  input wire adaptor_id_enable_out,
  input wire main_link_enable_out,
  input wire low_power_out,
  input wire source_ddc_data_oe,
  input wire sink_ddc_data_oe,
  input wire source_ddc_clock_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // override history: forced outputs lag the control by two edges
  // ----------------------------------------
  reg [3:0] force_hist_r;
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      force_hist_r <= 4'hf;
    else
      force_hist_r <= {force_hist_r[2:0], force_mode_in};
  end
  wire quiet = (force_hist_r == 4'h0) & ~force_mode_in;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_pullup;
    ddc_pullup_enable_out == source_cable_adapter_out;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable differs from adapter output");
  property p_idle_hp;
    (low_power_out && quiet) |-> !source_hotplug_out;
  endproperty
  a_idle_hp: assert property (p_idle_hp)
    else $error("hotplug high with no sink selected");
  property p_dp_aux;
    source_aux_channel_switch_out |-> sink_aux_channel_switch_out &&
      link_train_monitor_out && !source_ddc_switch_out &&
      !ddc_level_buffer_enable_out && !adaptor_id_enable_out;
  endproperty
  a_dp_aux: assert property (p_dp_aux)
    else $error("aux mode controls inconsistent");
  property p_tmds;
    ddc_level_buffer_enable_out |-> adaptor_id_enable_out &&
      source_ddc_switch_out && !sink_aux_channel_switch_out &&
      !source_aux_channel_switch_out;
  endproperty
  a_tmds: assert property (p_tmds)
    else $error("hdmi mode controls inconsistent");
  property p_tmds_cad;
    (ddc_level_buffer_enable_out && quiet) |-> source_cable_adapter_out;
  endproperty
  a_tmds_cad: assert property (p_tmds_cad)
    else $error("adapter output low in hdmi mode");
  property p_lowpow;
    low_power_out |-> !(source_aux_channel_switch_out ||
      source_ddc_switch_out || sink_aux_channel_switch_out ||
      ddc_level_buffer_enable_out || link_train_monitor_out ||
      adaptor_id_enable_out);
  endproperty
  a_lowpow: assert property (p_lowpow)
    else $error("switch on in low power mode");
  property p_ddc_src;
    ($fell(source_ddc_data_in) && ddc_level_buffer_enable_out) |->
      ##[1:8] (source_ddc_data_oe && sink_ddc_data_oe);
  endproperty
  a_ddc_src: assert property (p_ddc_src)
    else $error("source low not passed to sink");
  property p_ddc_snk;
    ($fell(sink_ddc_clock_in) && ddc_level_buffer_enable_out &&
      source_ddc_clock_in) |-> ##[1:8] source_ddc_clock_oe;
  endproperty
  a_ddc_snk: assert property (p_ddc_snk)
    else $error("sink low not passed to source");
  property p_main_off;
    (!enable_in) [*8] |-> !main_link_enable_out;
  endproperty
  a_main_off: assert property (p_main_off)
    else $error("main link on while enable low");
endmodule
bind dsh_ctl dsh_ctl_props #(.T_SWITCH_CYC(T_SWITCH_CYC),
  .T_PAUSE_CYC(T_PAUSE_CYC), .T_DISC_CYC(T_DISC_CYC)) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .enable_in(enable_in),
  .force_mode_in(force_mode_in), .source_ddc_data_in(source_ddc_data_in),
  .source_ddc_clock_in(source_ddc_clock_in),
  .sink_ddc_clock_in(sink_ddc_clock_in),
  .source_hotplug_out(source_hotplug_out),
  .source_cable_adapter_out(source_cable_adapter_out),
  .ddc_pullup_enable_out(ddc_pullup_enable_out),
  .source_aux_channel_switch_out(source_aux_channel_switch_out),
  .source_ddc_switch_out(source_ddc_switch_out),
  .sink_aux_channel_switch_out(sink_aux_channel_switch_out),
  .ddc_level_buffer_enable_out(ddc_level_buffer_enable_out),
  .link_train_monitor_out(link_train_monitor_out),
  .adaptor_id_enable_out(adaptor_id_enable_out),
  .main_link_enable_out(main_link_enable_out),
  .low_power_out(low_power_out), .source_ddc_data_oe(source_ddc_data_oe),
  .sink_ddc_data_oe(sink_ddc_data_oe),
  .source_ddc_clock_oe(source_ddc_clock_oe));

// [testbench/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) check_bit((g), (e))
module testbench;
  localparam integer T_SW = 20;
  localparam integer T_PS = 5;
  localparam integer T_DC = 16;
  reg clk_sys = 1'b0, resetn = 1'b0, enable_in = 1'b1, priority_in = 1'b0;
  reg dp_p = 1'b0, tm_p = 1'b0, tm_ad = 1'b0, hold_d = 1'b0, hold_c = 1'b0;
  reg lls = 1'b1, force_mode_in = 1'b0, force_hp = 1'b0, force_cad = 1'b0;
  reg src_pull = 1'b0;
  wire dp_hp, tm_hp, cad_in, snk_d, snk_c, hp, cad, pu, aux_sw, ddc_sw;
  wire snk_aux, lvl_buf, mon, aid, main_en, lp, lls_out;
  wire src_d_oe, src_c_oe, snk_d_oe, snk_c_oe;
  wire src_d_o, src_c_o, snk_d_o, snk_c_o;
  integer mismatches = 0, check_count = 0, n;
  reg ok;
  always #20 clk_sys = ~clk_sys;
  dsh_ctl #(.T_SWITCH_CYC(T_SW), .T_PAUSE_CYC(T_PS), .T_DISC_CYC(T_DC)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .enable_in(enable_in),
    .priority_in(priority_in), .dp_sink_hotplug_in(dp_hp),
    .tmds_sink_hotplug_in(tm_hp), .sink_cable_adapter_in(cad_in),
    .ddc_low_level_select(lls), .force_mode_in(force_mode_in),
    .force_hotplug_in(force_hp), .force_cable_adapter_in(force_cad),
    .source_ddc_data_in(~src_pull), .source_ddc_clock_in(~src_pull),
    .sink_ddc_data_in(snk_d), .sink_ddc_clock_in(snk_c),
    .source_hotplug_out(hp), .source_cable_adapter_out(cad),
    .ddc_pullup_enable_out(pu), .source_aux_channel_switch_out(aux_sw),
    .source_ddc_switch_out(ddc_sw), .sink_aux_channel_switch_out(snk_aux),
    .ddc_level_buffer_enable_out(lvl_buf), .link_train_monitor_out(mon),
    .adaptor_id_enable_out(aid), .main_link_enable_out(main_en),
    .low_power_out(lp), .ddc_low_level_select_out(lls_out),
    .source_ddc_data_out(src_d_o), .source_ddc_data_oe(src_d_oe),
    .source_ddc_clock_out(src_c_o), .source_ddc_clock_oe(src_c_oe),
    .sink_ddc_data_out(snk_d_o), .sink_ddc_data_oe(snk_d_oe),
    .sink_ddc_clock_out(snk_c_o), .sink_ddc_clock_oe(snk_c_oe));
  dsh_sink_model u_sinks (.dp_present(dp_p), .tmds_present(tm_p),
    .tmds_adapter(tm_ad), .hold_data_low(hold_d), .hold_clock_low(hold_c),
    .sink_ddc_data_oe(snk_d_oe), .sink_ddc_clock_oe(snk_c_oe),
    .dp_sink_hotplug_in(dp_hp), .tmds_sink_hotplug_in(tm_hp),
    .sink_cable_adapter_in(cad_in), .sink_ddc_data_in(snk_d),
    .sink_ddc_clock_in(snk_c));
  task check_bit(input logic got, input logic exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input integer k);
  begin
    repeat (k) @(posedge clk_sys);
    #1;
  end
  endtask
  // bounded wait; n returns cycles spent
  task wait_hp(input logic v);
  begin
    n = 0;
    while (hp !== v && n < 200)
    begin
      cyc(1);
      n = n + 1;
    end
    `CHK(hp, v);
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_idle;
  begin
    cyc(8);
    `CHK(lp, 1'b1);
    `CHK(hp, 1'b0);
    `CHK(aux_sw | ddc_sw | snk_aux | lvl_buf | mon | aid, 1'b0);
    `CHK(lls_out, 1'b1);
    @(posedge clk_sys) lls <= 1'b0;
    cyc(6);
    `CHK(lls_out, 1'b0);
    $display("test idle done");
  end
  endtask
  task t_dp;
  begin
    @(posedge clk_sys) dp_p <= 1'b1;
    wait_hp(1'b1);
    cyc(2);
    `CHK(hp, 1'b1);
    `CHK(aux_sw & mon & snk_aux, 1'b1);
    `CHK(cad | pu, 1'b0);
    @(posedge clk_sys) tm_ad <= 1'b1;
    cyc(8);
    `CHK(cad & pu, 1'b1);
    `CHK(ddc_sw & snk_aux & ~aux_sw & ~mon, 1'b1);
    @(posedge clk_sys) tm_ad <= 1'b0;
    cyc(8);
    $display("test dp done");
  end
  endtask
  task t_disc;
  begin
    @(posedge clk_sys) dp_p <= 1'b0;
    ok = 1'b1;
    repeat (8) begin cyc(1); ok = ok & (hp === 1'b1); end
    @(posedge clk_sys) dp_p <= 1'b1;
    repeat (30) begin cyc(1); ok = ok & (hp === 1'b1); end
    `CHK(ok, 1'b1);
    @(posedge clk_sys) dp_p <= 1'b0;
    wait_hp(1'b0);
    `CHK(n >= T_DC && n <= T_DC + 8, 1'b1);
    cyc(2);
    `CHK(lp, 1'b1);
    `CHK(cad, 1'b0);
    $display("test disconnect done");
  end
  endtask
  task t_tmds;
  begin
    @(posedge clk_sys) tm_p <= 1'b1;
    wait_hp(1'b1);
    cyc(2);
    `CHK(cad, 1'b1);
    `CHK(lvl_buf & aid & ddc_sw & ~snk_aux & ~aux_sw, 1'b1);
    @(posedge clk_sys) src_pull <= 1'b1;
    cyc(8);
    `CHK(src_d_oe & snk_d_oe & src_c_oe & snk_c_oe, 1'b1);
    `CHK(src_d_o | src_c_o | snk_d_o | snk_c_o, 1'b0);
    @(posedge clk_sys) src_pull <= 1'b0;
    cyc(12);
    `CHK(src_d_oe | snk_d_oe | src_c_oe | snk_c_oe, 1'b0);
    @(posedge clk_sys) hold_c <= 1'b1;
    cyc(8);
    `CHK(src_c_oe & ~snk_c_oe, 1'b1);
    @(posedge clk_sys) hold_c <= 1'b0;
    cyc(8);
    `CHK(src_c_oe, 1'b0);
    @(posedge clk_sys) tm_p <= 1'b0;
    wait_hp(1'b0);
    cyc(2);
    `CHK(lp & cad & pu, 1'b1);
    $display("test hdmi done");
  end
  endtask
  task t_prio;
  begin
    @(posedge clk_sys) dp_p <= 1'b1;
    tm_p <= 1'b1;
    wait_hp(1'b1);
    cyc(2);
    `CHK(aux_sw & ~lvl_buf, 1'b1);
    @(posedge clk_sys) priority_in <= 1'b1;
    cyc(10);
    `CHK(hp & aux_sw, 1'b1);
    wait_hp(1'b0);
    `CHK(n + 10 >= T_SW && n + 10 <= T_SW + 12, 1'b1);
    wait_hp(1'b1);
    `CHK(n >= T_PS - 1 && n <= T_PS + 2, 1'b1);
    cyc(2);
    `CHK(lvl_buf & ~aux_sw, 1'b1);
    @(posedge clk_sys) priority_in <= 1'b0;
    cyc(10);
    `CHK(hp & lvl_buf & cad, 1'b1);
    wait_hp(1'b0);
    wait_hp(1'b1);
    cyc(2);
    `CHK(aux_sw & ~lvl_buf, 1'b1);
    @(posedge clk_sys) priority_in <= 1'b1;
    wait_hp(1'b0);
    wait_hp(1'b1);
    cyc(2);
    `CHK(lvl_buf & ~aux_sw, 1'b1);
    $display("test priority done");
  end
  endtask
  task t_enable;
  begin
    @(posedge clk_sys) enable_in <= 1'b0;
    cyc(10);
    `CHK(main_en, 1'b0);
    `CHK(hp & lvl_buf, 1'b1);
    @(posedge clk_sys) enable_in <= 1'b1;
    cyc(10);
    `CHK(main_en, 1'b1);
    $display("test enable done");
  end
  endtask
  task t_override;
  begin
    @(posedge clk_sys) force_mode_in <= 1'b1;
    cyc(6);
    `CHK(hp | cad | pu, 1'b0);
    @(posedge clk_sys) force_hp <= 1'b1;
    cyc(6);
    `CHK(hp & ~cad, 1'b1);
    @(posedge clk_sys) force_cad <= 1'b1;
    cyc(6);
    `CHK(hp & cad & pu, 1'b1);
    @(posedge clk_sys) force_mode_in <= 1'b0;
    force_hp <= 1'b0;
    force_cad <= 1'b0;
    cyc(6);
    `CHK(hp & cad, 1'b1);
    $display("test override done");
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    t_idle;
    t_dp;
    t_disc;
    t_tmds;
    t_prio;
    t_enable;
    t_override;
    end_of_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches = mismatches + 1;
    end_of_test;
  end
endmodule
